// File: core/acc_pkg.sv
/*
 * Shared constants for the converter conversion-control block.
 * Assumes a single 40 MHz clock; the SAR bit decisions arrive as an input word.
 */
package acc_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 25;
   // acquisition time in ns, least time, rounds up
   localparam int unsigned ACQ_TIME_NS     = 400;
   localparam int unsigned ACQ_CYCLES      = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // cycles spent per successive-approximation bit decision
   localparam int unsigned CYCLES_PER_BIT  = 4;
   localparam int unsigned RESULT_WIDTH    = 16;
   localparam int unsigned CNT_WIDTH       = 8;
   localparam int unsigned BIT_IDX_WIDTH   = 5;
   localparam logic [15:0] RESULT_RESET    = 16'h0000;

   typedef enum logic [1:0] {
      ACC_ACQUIRE,
      ACC_WAIT_EDGE,
      ACC_CONVERT
   } acc_state_t;
endpackage : acc_pkg

// File: core/acc_shift_out.sv
/*
 * Result shift register for the serial port with external shift clock.
 * Assumes the shift clock arrives as a synchronous level sampled on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module acc_shift_out #(
   parameter int unsigned WIDTH = acc_pkg::RESULT_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic             cs_n_i,
   input  wire logic             sclk_i,
   output logic                  sdo_o,
   output logic                  reading_o
);
   logic [WIDTH-1:0] sr_q;
   logic [WIDTH-1:0] sr_d;
   logic             sclk_q;
   logic             sclk_d;
   logic             rd_q;
   logic             rd_d;
   logic             rise;
   // shift count since load; a full count means the read is finished
   localparam int unsigned NW = $clog2(WIDTH + 1);
   logic [NW-1:0]    n_q;
   logic [NW-1:0]    n_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sr_d   = sr_q;
      rd_d   = rd_q;
      n_d    = n_q;
      sclk_d = sclk_i;
      rise   = sclk_i && !sclk_q && !cs_n_i;
      if (load_i) begin
         sr_d = data_i;
         rd_d = 1'b0;
         n_d  = '0;
      end else if (rise && n_q != NW'(WIDTH)) begin
         sr_d = {sr_q[WIDTH-2:0], 1'b0};
         n_d  = n_q + 1'b1;
         // read counts as finished once every bit has gone
         rd_d = (n_q != NW'(WIDTH - 1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sr_q   <= '0;
         sclk_q <= 1'b0;
         rd_q   <= 1'b0;
         n_q    <= '0;
      end else if (ce_i) begin
         sr_q   <= sr_d;
         sclk_q <= sclk_d;
         rd_q   <= rd_d;
         n_q    <= n_d;
      end
   end

   assign sdo_o     = sr_q[WIDTH-1];
   assign reading_o = rd_q;
endmodule : acc_shift_out
`default_nettype wire

// File: core/acc_conv_ctrl.sv
/*
 * Conversion control: start, busy, power-down, reset abort, gated output bus.
 * Assumes synchronous pins; the SAR comparator result word arrives on
 * SAR_WORD_I and is captured at the end of conversion.
 */
//
// Contract
// - busy rises as soon as a conversion begins.
// - busy stays high until result loads the shift register, then falls.
// - output bus enabled only while select and read both low.
// - external shift clock ignored unless select is low.
// - reset high aborts conversion, no result produced.
// - power-down lets current conversion finish, blocks new ones.
// - start high at acquisition end: wait falling edge, then convert.
// - start low at acquisition end: convert immediately.
// - serial result shifts out most significant bit first.
// - unfinished external-clock read when next conversion ends: discard, pulse flag.
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl #(
   parameter int unsigned WIDTH      = acc_pkg::RESULT_WIDTH,
   parameter int unsigned ACQ_CYC    = acc_pkg::ACQ_CYCLES,
   parameter int unsigned BIT_CYC    = acc_pkg::CYCLES_PER_BIT
) (
   input  wire logic             CLK_I,
   input  wire logic             RST_I,
   input  wire logic             CE_I,
   input  wire logic             CONVERSION_START_N_I,
   input  wire logic             POWER_DOWN_REQUEST_I,
   input  wire logic             CS_N_I,
   input  wire logic             RD_N_I,
   input  wire logic             PORT_MODE_SELECT_I,
   input  wire logic             SHIFT_CLOCK_SOURCE_SELECT_I,
   input  wire logic             SCLK_I,
   input  wire logic [WIDTH-1:0] SAR_WORD_I,
   output logic                  BUSY_O,
   output logic                  HOLD_O,
   output logic [WIDTH-1:0]      DATA_O,
   output logic                  DATA_OE_N_O,
   output logic                  SERIAL_RESULT_OUT_O,
   output logic                  INCOMPLETE_READ_FLAG_O
);
   acc_pkg::acc_state_t                 st_q;
   acc_pkg::acc_state_t                 st_d;
   logic [acc_pkg::CNT_WIDTH-1:0]       cnt_q;
   logic [acc_pkg::CNT_WIDTH-1:0]       cnt_d;
   logic [acc_pkg::BIT_IDX_WIDTH-1:0]   bit_q;
   logic [acc_pkg::BIT_IDX_WIDTH-1:0]   bit_d;
   logic                                start_q;
   logic                                start_d;
   logic [WIDTH-1:0]                    res_q;
   logic [WIDTH-1:0]                    res_d;
   logic                                err_q;
   logic                                err_d;
   logic                                done;
   logic                                start_fall;
   logic                                sdo;
   logic                                reading;
   logic                                ext_ser;

   localparam logic [acc_pkg::CNT_WIDTH-1:0]     ACQ_LAST = acc_pkg::CNT_WIDTH'(ACQ_CYC - 1);
   localparam logic [acc_pkg::CNT_WIDTH-1:0]     BIT_LAST = acc_pkg::CNT_WIDTH'(BIT_CYC - 1);
   localparam logic [acc_pkg::BIT_IDX_WIDTH-1:0] BIT_TOP  =
      acc_pkg::BIT_IDX_WIDTH'(WIDTH - 1);

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   always_comb begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      bit_d      = bit_q;
      res_d      = res_q;
      done       = 1'b0;
      start_d    = CONVERSION_START_N_I;
      start_fall = start_q && !CONVERSION_START_N_I;
      unique case (st_q)
         acc_pkg::ACC_ACQUIRE: begin
            if (cnt_q != ACQ_LAST) begin
               cnt_d = cnt_q + 1'b1;
            end else if (!POWER_DOWN_REQUEST_I) begin
               cnt_d = '0;
               bit_d = BIT_TOP;
               if (!CONVERSION_START_N_I) begin
                  st_d = acc_pkg::ACC_CONVERT;
               end else begin
                  st_d = acc_pkg::ACC_WAIT_EDGE;
               end
            end
         end
         acc_pkg::ACC_WAIT_EDGE: begin
            if (start_fall && !POWER_DOWN_REQUEST_I) begin
               st_d = acc_pkg::ACC_CONVERT;
            end
         end
         acc_pkg::ACC_CONVERT: begin
            // conversion runs to its end regardless of start and power-down; only reset aborts it
            if (cnt_q != BIT_LAST) begin
               cnt_d = cnt_q + 1'b1;
            end else begin
               cnt_d = '0;
               if (bit_q != '0) begin
                  bit_d = bit_q - 1'b1;
               end else begin
                  res_d = SAR_WORD_I;
                  done  = 1'b1;
                  st_d  = acc_pkg::ACC_ACQUIRE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_q    <= acc_pkg::ACC_ACQUIRE;
         cnt_q   <= '0;
         bit_q   <= '0;
         start_q <= 1'b1;
         res_q   <= acc_pkg::RESULT_RESET;
      end else if (CE_I) begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         bit_q   <= bit_d;
         start_q <= start_d;
         res_q   <= res_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial port and read error
   assign ext_ser = PORT_MODE_SELECT_I && SHIFT_CLOCK_SOURCE_SELECT_I;

   acc_shift_out #(
      .WIDTH (WIDTH)
   ) u_shift (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .ce_i      (CE_I),
      .load_i    (done),
      .data_i    (SAR_WORD_I),
      .cs_n_i    (CS_N_I),
      .sclk_i    (SCLK_I),
      .sdo_o     (sdo),
      .reading_o (reading)
   );

   always_comb begin
      // one-cycle flag when a partly read result is overwritten in external-clock serial mode
      err_d = done && reading && ext_ser;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         err_q <= 1'b0;
      end else if (CE_I) begin
         err_q <= err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy follows conversion state
   assign BUSY_O                 = (st_q == acc_pkg::ACC_CONVERT);
   assign HOLD_O                 = (st_q == acc_pkg::ACC_CONVERT);
   assign DATA_O                 = res_q;
   // bus enable needs select and read low
   assign DATA_OE_N_O            = CS_N_I || RD_N_I;
   assign SERIAL_RESULT_OUT_O    = sdo;
   assign INCOMPLETE_READ_FLAG_O = err_q;
endmodule : acc_conv_ctrl
`default_nettype wire

// File: tb/acc_monitor.sv
/*
 * Port checker for the conversion control block.
 * Assumes one clock; bound onto every acc_conv_ctrl.
 */
`timescale 1ns/100ps
`default_nettype none
module acc_monitor #(
   parameter int unsigned WIDTH   = 16,
   parameter int unsigned ACQ_CYC = 16,
   parameter int unsigned BIT_CYC = 4
) (
   input wire logic             CLK_I,
   input wire logic             RST_I,
   input wire logic             CONVERSION_START_N_I,
   input wire logic             POWER_DOWN_REQUEST_I,
   input wire logic             CS_N_I,
   input wire logic             RD_N_I,
   input wire logic             BUSY_O,
   input wire logic             HOLD_O,
   input wire logic             INCOMPLETE_READ_FLAG_O,
   input wire logic [WIDTH-1:0] DATA_O,
   input wire logic             DATA_OE_N_O
);
   int hi_q;
   int lo_q;
   // samples seen high and low since the last change of busy
   always_ff @(posedge CLK_I) begin
      hi_q <= (RST_I || !BUSY_O) ? 0 : hi_q + 1;
      lo_q <= (RST_I || BUSY_O) ? 0 : lo_q + 1;
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   chk_oe_gate: assert property (DATA_OE_N_O == (CS_N_I | RD_N_I))
      else $error("output enable wrong");
   chk_reset_idle: assert property (disable iff (1'b0) RST_I |=> !BUSY_O && DATA_O == '0)
      else $error("reset left busy or data");
   chk_busy_len: assert property ($fell(BUSY_O) && !$past(RST_I) |-> hi_q == WIDTH*BIT_CYC)
      else $error("busy length wrong");
   chk_data_load: assert property ($changed(DATA_O) && !$past(RST_I) |-> $fell(BUSY_O))
      else $error("data changed off busy fall");
   chk_acq_gap: assert property ($rose(BUSY_O) |-> lo_q >= ACQ_CYC)
      else $error("acquisition too short");
   chk_pd_block: assert property (POWER_DOWN_REQUEST_I && !BUSY_O |=> !BUSY_O)
      else $error("start under power down");
   chk_start_cause: assert property ($rose(BUSY_O) |-> !$past(CONVERSION_START_N_I))
      else $error("busy rose without start");
   chk_start_now: assert property (!BUSY_O && lo_q >= ACQ_CYC-1 && !CONVERSION_START_N_I
      && !POWER_DOWN_REQUEST_I |=> BUSY_O)
      else $error("held start not taken");
   chk_hold_conv: assert property (HOLD_O == BUSY_O)
      else $error("hold not matching conversion");
   chk_flag_pulse: assert property (INCOMPLETE_READ_FLAG_O |=> !INCOMPLETE_READ_FLAG_O)
      else $error("flag longer than one cycle");
endmodule : acc_monitor
bind acc_conv_ctrl acc_monitor #(.WIDTH(WIDTH), .ACQ_CYC(ACQ_CYC), .BIT_CYC(BIT_CYC)) u_mon (
   .CLK_I(CLK_I), .RST_I(RST_I), .CONVERSION_START_N_I(CONVERSION_START_N_I),
   .POWER_DOWN_REQUEST_I(POWER_DOWN_REQUEST_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I),
   .BUSY_O(BUSY_O), .HOLD_O(HOLD_O), .INCOMPLETE_READ_FLAG_O(INCOMPLETE_READ_FLAG_O),
   .DATA_O(DATA_O), .DATA_OE_N_O(DATA_OE_N_O));
`default_nettype wire

// File: tb/acc_host_model.sv
/*
 * Host model: reads the serial result after busy falls.
 * Assumes the bench sets the bit count; zero means no read.
 */
`timescale 1ns/100ps
`default_nettype none
module acc_host_model (
   input  wire logic  clk_i,
   input  wire logic  busy_i,
   input  wire logic  sdo_i,
   input  var  int    n_bits_i,
   output logic       cs_n_o,
   output logic       rd_n_o,
   output logic       sclk_o,
   output logic       done_o,
   output logic [15:0] word_o
);
   // level held two cycles so the sampled edge is seen
   task automatic step(input logic s);
      @(posedge clk_i);
      @(posedge clk_i);
      #1 sclk_o = s;
   endtask : step
   initial begin
      {cs_n_o, rd_n_o, sclk_o, done_o} = 4'b1101;
      word_o = '0;
      forever begin
         @(negedge busy_i);
         done_o = 1'b0;
         if (n_bits_i > 0) begin
            step(1'b1);
            step(1'b0);
            // select and read held through the read
            {cs_n_o, rd_n_o} = 2'b00;
            for (int i = 0; i < n_bits_i; i++) begin
               word_o = {word_o[14:0], sdo_i};
               step(1'b1);
               step(1'b0);
            end
            {cs_n_o, rd_n_o} = 2'b11;
         end
         done_o = 1'b1;
      end
   end
endmodule : acc_host_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Bench for acc_conv_ctrl with the host model on the result port.
 * Assumes serial mode with external shift clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, start_n = 1'b1, pd = 1'b0;
   logic        cs_n, rd_n, sclk, busy, oe_n, sdo, flag, done;
   logic [15:0] sar = 16'h0000, data, word;
   int          n_bits = 16, error_cnt = 0, n_checks = 0;
   logic [15:0] tbl [3][2] = '{'{16'h8001, 16'h8001}, '{16'h7ffe, 16'h7ffe},
                               '{16'ha5c3, 16'ha5c3}};
   always #12.5 clk = ~clk;
   // short acquisition and one cycle a bit keep the run brief
   acc_conv_ctrl #(.ACQ_CYC(4), .BIT_CYC(1)) dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
      .CONVERSION_START_N_I(start_n), .POWER_DOWN_REQUEST_I(pd), .CS_N_I(cs_n),
      .RD_N_I(rd_n), .PORT_MODE_SELECT_I(1'b1), .SHIFT_CLOCK_SOURCE_SELECT_I(1'b1),
      .SCLK_I(sclk), .SAR_WORD_I(sar), .BUSY_O(busy), .HOLD_O(), .DATA_O(data),
      .DATA_OE_N_O(oe_n), .SERIAL_RESULT_OUT_O(sdo), .INCOMPLETE_READ_FLAG_O(flag));
   acc_host_model host (.clk_i(clk), .busy_i(busy), .sdo_i(sdo), .n_bits_i(n_bits),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk), .done_o(done), .word_o(word));
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wt(input bit d, input logic v);
      for (int i = 0; i < 300 && (d ? done : busy) !== v; i++) cyc(1);
      chk("wait", 16'(d ? done : busy), 16'(v));
   endtask : wt
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      #75000;
      error_cnt++;
      test_done();
   end
   initial begin
      cyc(12);
      rst = 1'b0;
      chk("busy", 16'(busy), 16'h0000);
      chk("data", data, 16'h0000);
      cyc(8);
      foreach (tbl[r]) begin
         sar = tbl[r][0];
         start_n = 1'b0;
         cyc(1);
         start_n = 1'b1;
         chk("busy", 16'(busy), 16'h0001);
         wt(0, 1'b0);
         chk("data", data, tbl[r][1]);
         chk("no flag", 16'(flag), 16'h0000);
         wt(1, 1'b1);
         chk("serial", word, tbl[r][1]);
         chk("oe off", 16'(oe_n), 16'h0001);
         $display("row %0d done", r);
      end
      sar = 16'h1234;
      n_bits = 0;
      start_n = 1'b0;
      cyc(5);
      rst = 1'b1;
      cyc(1);
      rst = 1'b0;
      start_n = 1'b1;
      chk("abort busy", 16'(busy), 16'h0000);
      chk("abort data", data, 16'h0000);
      chk("abort sdo", 16'(sdo), 16'h0000);
      $display("reset test done");
      cyc(8);
      start_n = 1'b0;
      cyc(3);
      pd = 1'b1;
      wt(0, 1'b0);
      chk("pd data", data, 16'h1234);
      cyc(30);
      chk("pd busy", 16'(busy), 16'h0000);
      pd = 1'b0;
      cyc(1);
      chk("resume", 16'(busy), 16'h0001);
      n_bits = 16;
      for (int i = 0; i < 300 && flag !== 1'b1; i++) cyc(1);
      chk("flag", 16'(flag), 16'h0001);
      cyc(1);
      chk("flag pulse", 16'(flag), 16'h0000);
      start_n = 1'b1;
      $display("power and flag tests done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
